/* cipher_mode_cfg.svh */
// Constants for the cipher mode switch control block.
`ifndef CIPHER_MODE_CFG_SVH
`define CIPHER_MODE_CFG_SVH
`define CLK_PERIOD_NS 4
`define FRAME_TIME_NS 10000000
`define FRAME_CYCLES (`FRAME_TIME_NS / `CLK_PERIOD_NS)
`define FRAME_W 4
`define KEY_W 8
`define TRY_W 3
`define PT_MAX_REQ 3'h5
`define FT_MAX_CONF 3'h6
`endif

/* cipher_mode_pkg.sv */
// Types for the cipher mode switch control block.
package cipher_mode_pkg;
    typedef enum logic [2:0] {
        MSG_NONE = 3'h0,
        MSG_START_REQ = 3'h1,
        MSG_START_CONF = 3'h2,
        MSG_START_REJECT = 3'h3,
        MSG_START_GRANT = 3'h4,
        MSG_STOP_REQ = 3'h5,
        MSG_STOP_CONF = 3'h6,
        MSG_STOP_GRANT = 3'h7
    } msg_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_REQ = 2'h1,
        ST_CONF = 2'h3,
        ST_REKEY = 2'h2
    } state_t;
endpackage : cipher_mode_pkg

/* cipher_mode_switch_control.sv */
// Frame-synchronous clear/encrypt mode switching for either link end.
`timescale 1ns/1ps
`include "cipher_mode_cfg.svh"
// How it works
// - Portable repeats stop request each even frame.
// - Fixed repeats stop confirm each odd frame.
// - Portable sends stop grant next even frame.
// - Start request repeated at most five even frames.
// - Reject valid only for default-key request.
// - Portable releases when no confirm or reject.
// - Portable ignores receive data until start confirm.
// - Start grant next even; encrypt from then.
// - Fixed encrypts at once, confirms until S+11.
// - Fixed releases when start grant never arrives.
// - Fixed decrypts from frame after grant, reports grant.
// - Default-key messages carry the key index.
// - Stop request five even frames, else release.
// - Portable stops decrypting at stop confirm.
// - Stop grant next even; clear from then.
// - Fixed clears at once, stop confirms, else release.
// - Fixed decrypts until stop grant, ignores between.
// - Re-key stops, then restarts with new key.
// - Default-key re-keying begins only at portable.
// - Portable even frames, fixed odd, never encrypted.
// - Mode applies to every bearer of connection.
module cipher_mode_switch_control
    import cipher_mode_pkg::*;
#(
    parameter int FRAME_CYCLES = `FRAME_CYCLES
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic role_fixed,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic use_default_key,
    input wire logic [`KEY_W-1:0] key_index,
    input wire logic refuse_default,
    input wire logic rx_valid,
    input wire msg_t rx_msg,
    input wire logic rx_default,
    input wire logic [`KEY_W-1:0] rx_key_index,
    output logic frame_tick,
    output logic [`FRAME_W-1:0] frame_num,
    output logic tx_valid,
    output msg_t tx_msg,
    output logic tx_default,
    output logic [`KEY_W-1:0] tx_key_index,
    output logic tx_encrypt,
    output logic rx_decrypt,
    output logic rx_discard,
    output logic bearer_encrypt,
    output logic busy,
    output logic eks_cfm,
    output logic eks_ind,
    output logic dis_ind
);
    logic [31:0] div_r;
    logic [`FRAME_W-1:0] frame_r;
    msg_t hold_r;
    logic hold_def_r;
    msg_t rx_now;
    logic rx_def_now;
    logic even_nxt;
    state_t state_r;
    logic stop_r;
    logic rekey_r;
    logic def_r;
    logic [`KEY_W-1:0] key_r;
    logic [`TRY_W-1:0] tries_r;

    // Frame boundary divider and frame number; parity is the low bit.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_r <= 32'h0;
            frame_r <= '0;
        end
        else if (div_r == 32'(FRAME_CYCLES - 1))
        begin
            div_r <= 32'h0;
            frame_r <= frame_r + `FRAME_W'(1);
        end
        else
        begin
            div_r <= div_r + 32'h1;
        end
    end

    assign frame_tick = (div_r == 32'(FRAME_CYCLES - 1));
    assign frame_num = frame_r;
    assign even_nxt = frame_r[0];
    assign bearer_encrypt = tx_encrypt;
    assign busy = (state_r != ST_IDLE);

    // A message received during a frame is acted on at the frame boundary.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_r <= MSG_NONE;
            hold_def_r <= 1'b0;
        end
        else if (frame_tick)
        begin
            hold_r <= MSG_NONE;
            hold_def_r <= 1'b0;
        end
        else if (rx_valid)
        begin
            hold_r <= rx_msg;
            hold_def_r <= rx_default;
        end
    end

    assign rx_now = rx_valid ? rx_msg : hold_r;
    assign rx_def_now = rx_valid ? rx_default : hold_def_r;

    // Mode-switch handshake; all transmit decisions hold for one frame.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_IDLE;
            stop_r <= 1'b0;
            rekey_r <= 1'b0;
            def_r <= 1'b0;
            key_r <= '0;
            tries_r <= '0;
            tx_valid <= 1'b0;
            tx_msg <= MSG_NONE;
            tx_default <= 1'b0;
            tx_key_index <= '0;
            tx_encrypt <= 1'b0;
            rx_decrypt <= 1'b0;
            rx_discard <= 1'b0;
            eks_cfm <= 1'b0;
            eks_ind <= 1'b0;
            dis_ind <= 1'b0;
        end
        else
        begin
            eks_cfm <= 1'b0;
            eks_ind <= 1'b0;
            dis_ind <= 1'b0;
            if (frame_tick)
            begin
                tx_valid <= 1'b0;
                tx_msg <= MSG_NONE;
                tx_default <= def_r;
                tx_key_index <= key_r;
            end
            if (!role_fixed && state_r == ST_IDLE && (start_req || stop_req))
            begin
                // Re-keying is a stop followed by a start with the new key.
                state_r <= ST_REQ;
                tries_r <= '0;
                stop_r <= stop_req || tx_encrypt;
                rekey_r <= start_req && tx_encrypt;
                def_r <= use_default_key;
                key_r <= key_index;
            end
            else if (frame_tick && !role_fixed)
            begin
                unique case (state_r)
                    ST_IDLE:
                    begin
                    end
                    ST_REQ:
                    begin
                        if (even_nxt && rx_now == (stop_r ? MSG_STOP_CONF : MSG_START_CONF))
                        begin
                            // Grant goes out in the even frame after the confirm.
                            tx_valid <= 1'b1;
                            tx_msg <= stop_r ? MSG_STOP_GRANT : MSG_START_GRANT;
                            tx_encrypt <= !stop_r;
                            rx_decrypt <= !stop_r;
                            rx_discard <= 1'b0;
                            eks_cfm <= 1'b1;
                            state_r <= (stop_r && rekey_r) ? ST_REKEY : ST_IDLE;
                        end
                        else if (!stop_r && rx_now == MSG_START_REJECT && def_r)
                        begin
                            eks_cfm <= 1'b1;
                            rx_discard <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                        else if (even_nxt)
                        begin
                            if (tries_r == `PT_MAX_REQ)
                            begin
                                dis_ind <= 1'b1;
                                rx_discard <= 1'b0;
                                state_r <= ST_IDLE;
                            end
                            else
                            begin
                                tx_valid <= 1'b1;
                                tx_msg <= stop_r ? MSG_STOP_REQ : MSG_START_REQ;
                                tries_r <= tries_r + `TRY_W'(1);
                                rx_discard <= 1'b1;
                            end
                        end
                    end
                    ST_REKEY:
                    begin
                        if (even_nxt)
                        begin
                            tx_valid <= 1'b1;
                            tx_msg <= MSG_START_REQ;
                            tx_default <= def_r;
                            stop_r <= 1'b0;
                            rekey_r <= 1'b0;
                            tries_r <= `TRY_W'(1);
                            rx_discard <= 1'b1;
                            state_r <= ST_REQ;
                        end
                    end
                    ST_CONF:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
            else if (frame_tick && role_fixed)
            begin
                unique case (state_r)
                    ST_IDLE:
                    begin
                        if (!even_nxt && rx_now == MSG_START_REQ)
                        begin
                            tx_valid <= 1'b1;
                            def_r <= rx_def_now;
                            key_r <= rx_key_index;
                            tx_default <= rx_def_now;
                            tx_key_index <= rx_key_index;
                            if (rx_def_now && refuse_default)
                            begin
                                tx_msg <= MSG_START_REJECT;
                            end
                            else
                            begin
                                tx_msg <= MSG_START_CONF;
                                tx_encrypt <= 1'b1;
                                stop_r <= 1'b0;
                                tries_r <= `TRY_W'(1);
                                state_r <= ST_CONF;
                            end
                        end
                        else if (!even_nxt && rx_now == MSG_STOP_REQ)
                        begin
                            tx_valid <= 1'b1;
                            tx_msg <= MSG_STOP_CONF;
                            tx_encrypt <= 1'b0;
                            stop_r <= 1'b1;
                            tries_r <= `TRY_W'(1);
                            state_r <= ST_CONF;
                        end
                    end
                    ST_CONF:
                    begin
                        if (rx_now == (stop_r ? MSG_STOP_GRANT : MSG_START_GRANT))
                        begin
                            eks_ind <= 1'b1;
                            rx_decrypt <= !stop_r;
                            rx_discard <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                        else if (even_nxt)
                        begin
                            rx_discard <= 1'b1;
                        end
                        else if (tries_r == `FT_MAX_CONF)
                        begin
                            dis_ind <= 1'b1;
                            rx_discard <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                        else
                        begin
                            tx_valid <= 1'b1;
                            tx_msg <= stop_r ? MSG_STOP_CONF : MSG_START_CONF;
                            tries_r <= tries_r + `TRY_W'(1);
                        end
                    end
                    ST_REQ, ST_REKEY:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence pt_conf_seen;
        frame_tick && !role_fixed && state_r == ST_REQ && even_nxt
            && rx_now == (stop_r ? MSG_STOP_CONF : MSG_START_CONF);
    endsequence

    sequence ft_req_seen;
        frame_tick && role_fixed && state_r == ST_IDLE && !even_nxt
            && rx_now == MSG_START_REQ && !(rx_def_now && refuse_default);
    endsequence

    a_pt_even_only: assert property (tx_valid && !role_fixed |-> !frame_num[0])
        else $error("portable message in odd frame");
    a_ft_odd_only: assert property (tx_valid && role_fixed |-> frame_num[0])
        else $error("fixed message in even frame");
    a_pt_req_limit: assert property (!role_fixed |-> tries_r <= `PT_MAX_REQ)
        else $error("too many requests");
    a_ft_conf_limit: assert property (role_fixed |-> tries_r <= `FT_MAX_CONF)
        else $error("too many confirms");
    a_pt_grant_mode: assert property (pt_conf_seen |=> tx_valid && eks_cfm
            && tx_encrypt == (tx_msg == MSG_START_GRANT))
        else $error("grant or transmit mode wrong after confirm");
    a_ft_start_enc: assert property (ft_req_seen |=> tx_encrypt
            && tx_msg == MSG_START_CONF && !rx_discard)
        else $error("fixed side did not enter encrypt mode");
    a_ft_grant_dec: assert property (frame_tick && role_fixed && state_r == ST_CONF
            && !stop_r && rx_now == MSG_START_GRANT |=> rx_decrypt && eks_ind ##1 !eks_ind)
        else $error("grant not reported or decrypt not on");
    a_pt_release: assert property (frame_tick && !role_fixed && state_r == ST_REQ
            && even_nxt && tries_r == `PT_MAX_REQ && rx_now == MSG_NONE |=> dis_ind && !busy)
        else $error("portable did not release after retries");
    a_ft_release: assert property (frame_tick && role_fixed && state_r == ST_CONF
            && !even_nxt && tries_r == `FT_MAX_CONF && rx_now == MSG_NONE |=> dis_ind)
        else $error("fixed did not release after window");
endmodule : cipher_mode_switch_control

/* cipher_mode_switch_control_tb.sv */
// Self-checking bench for the cipher mode switch control block.
`timescale 1ns/1ps
`include "cipher_mode_cfg.svh"
module cipher_mode_switch_control_tb
    import cipher_mode_pkg::*;
;
    logic clk, reset_n, role_fixed, start_req, stop_req, use_default_key, refuse_default;
    logic [`KEY_W-1:0] key_index, rx_key_index, tx_key_index;
    logic rx_valid, rx_default, frame_tick, tx_valid, tx_default, tx_encrypt, rx_decrypt;
    logic rx_discard, bearer_encrypt, busy, eks_cfm, eks_ind, dis_ind;
    logic [`FRAME_W-1:0] frame_num;
    logic [2:0] mode;
    msg_t rx_msg, tx_msg;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    cipher_mode_switch_control #(.FRAME_CYCLES(8)) dut_u (.clk(clk), .reset_n(reset_n),
        .role_fixed(role_fixed), .start_req(start_req), .stop_req(stop_req),
        .use_default_key(use_default_key), .key_index(key_index),
        .refuse_default(refuse_default), .rx_valid(rx_valid), .rx_msg(rx_msg),
        .rx_default(rx_default), .rx_key_index(rx_key_index), .frame_tick(frame_tick),
        .frame_num(frame_num), .tx_valid(tx_valid), .tx_msg(tx_msg),
        .tx_default(tx_default), .tx_key_index(tx_key_index), .tx_encrypt(tx_encrypt),
        .rx_decrypt(rx_decrypt), .rx_discard(rx_discard), .bearer_encrypt(bearer_encrypt),
        .busy(busy), .eks_cfm(eks_cfm), .eks_ind(eks_ind), .dis_ind(dis_ind));
    peer_mac_model peer_u (.clk(clk), .reset_n(reset_n), .frame_tick(frame_tick),
        .frame_num(frame_num), .mode(mode), .tx_valid(tx_valid), .tx_msg(tx_msg),
        .tx_default(tx_default), .tx_key_index(tx_key_index), .rx_valid(rx_valid),
        .rx_msg(rx_msg), .rx_default(rx_default), .rx_key_index(rx_key_index));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic give_verdict();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic next_frame();
        int n;
        n = 0;
        @(negedge clk);
        while (frame_tick !== 1'b1 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        #1;
    endtask : next_frame
    task automatic wait_tx();
        int n;
        n = 0;
        next_frame();
        while (tx_valid !== 1'b1 && n < 6)
        begin
            next_frame();
            n++;
        end
    endtask : wait_tx
    task automatic expect_tx(input msg_t m);
        chk("tx_valid", 8'h1, tx_valid);
        chk("tx_msg", m, tx_msg);
        chk("frame_parity", role_fixed, frame_num[0]);
    endtask : expect_tx
    task automatic do_reset(input logic fixed, input logic [2:0] md);
        reset_n = 1'b0;
        role_fixed = fixed;
        mode = md;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
    endtask : do_reset
    task automatic request(input logic stp, input logic dflt, input logic [7:0] key);
        use_default_key = dflt;
        key_index = key;
        stop_req = stp;
        start_req = !stp;
        @(posedge clk);
        #1;
        start_req = 1'b0;
        stop_req = 1'b0;
    endtask : request
    task automatic count_tx(input msg_t m, input int frames, output int n, output int d);
        n = 0;
        d = 0;
        repeat (frames)
        begin
            next_frame();
            n += int'(tx_valid === 1'b1 && tx_msg === m);
            d += int'(dis_ind === 1'b1);
        end
    endtask : count_tx
    task automatic pt_reject_and_timeout();
        int n, d;
        do_reset(1'b0, 3'h2);
        request(1'b0, 1'b1, 8'h5a);
        wait_tx();
        expect_tx(MSG_START_REQ);
        chk("tx_default", 8'h1, tx_default);
        chk("tx_key_index", 8'h5a, tx_key_index);
        next_frame();
        next_frame();
        chk("eks_cfm", 8'h1, eks_cfm);
        chk("tx_valid", 8'h0, tx_valid);
        chk("tx_encrypt", 8'h0, tx_encrypt);
        chk("busy", 8'h0, busy);
        request(1'b0, 1'b0, 8'h33);
        count_tx(MSG_START_REQ, 16, n, d);
        chk("start_req_count", 8'h5, n[7:0]);
        chk("dis_ind_count", 8'h1, d[7:0]);
    endtask : pt_reject_and_timeout
    task automatic pt_start_rekey_stop();
        int n, d;
        do_reset(1'b0, 3'h1);
        request(1'b0, 1'b0, 8'h11);
        wait_tx();
        expect_tx(MSG_START_REQ);
        chk("rx_discard", 8'h1, rx_discard);
        chk("tx_encrypt", 8'h0, tx_encrypt);
        next_frame();
        chk("tx_valid", 8'h0, tx_valid);
        next_frame();
        expect_tx(MSG_START_GRANT);
        chk("eks_cfm", 8'h1, eks_cfm);
        chk("tx_encrypt", 8'h1, tx_encrypt);
        chk("rx_decrypt", 8'h1, rx_decrypt);
        chk("rx_discard", 8'h0, rx_discard);
        chk("bearer_encrypt", 8'h1, bearer_encrypt);
        request(1'b0, 1'b0, 8'h22);
        wait_tx();
        expect_tx(MSG_STOP_REQ);
        chk("rx_discard", 8'h1, rx_discard);
        next_frame();
        next_frame();
        expect_tx(MSG_STOP_GRANT);
        chk("tx_encrypt", 8'h0, tx_encrypt);
        chk("rx_decrypt", 8'h0, rx_decrypt);
        next_frame();
        next_frame();
        expect_tx(MSG_START_REQ);
        chk("tx_key_index", 8'h22, tx_key_index);
        next_frame();
        next_frame();
        expect_tx(MSG_START_GRANT);
        chk("tx_encrypt", 8'h1, tx_encrypt);
        mode = 3'h0;
        request(1'b1, 1'b0, 8'h22);
        count_tx(MSG_STOP_REQ, 16, n, d);
        chk("stop_req_count", 8'h5, n[7:0]);
        chk("dis_ind_count", 8'h1, d[7:0]);
    endtask : pt_start_rekey_stop
    task automatic ft_start_and_timeout();
        int n, d;
        do_reset(1'b1, 3'h3);
        wait_tx();
        expect_tx(MSG_START_CONF);
        chk("tx_encrypt", 8'h1, tx_encrypt);
        chk("rx_discard", 8'h0, rx_discard);
        chk("rx_decrypt", 8'h0, rx_decrypt);
        next_frame();
        chk("rx_discard", 8'h1, rx_discard);
        next_frame();
        chk("eks_ind", 8'h1, eks_ind);
        chk("rx_decrypt", 8'h1, rx_decrypt);
        chk("rx_discard", 8'h0, rx_discard);
        chk("tx_valid", 8'h0, tx_valid);
        mode = 3'h0;
        next_frame();
        mode = 3'h5;
        wait_tx();
        expect_tx(MSG_STOP_CONF);
        chk("tx_encrypt", 8'h0, tx_encrypt);
        chk("rx_decrypt", 8'h1, rx_decrypt);
        next_frame();
        chk("rx_discard", 8'h1, rx_discard);
        next_frame();
        chk("eks_ind", 8'h1, eks_ind);
        chk("rx_decrypt", 8'h0, rx_decrypt);
        chk("rx_discard", 8'h0, rx_discard);
        do_reset(1'b1, 3'h4);
        count_tx(MSG_START_CONF, 20, n, d);
        chk("start_conf_count", 8'h6, n[7:0]);
        chk("dis_ind_count", 8'h1, d[7:0]);
    endtask : ft_start_and_timeout
    task automatic ft_default_reject();
        refuse_default = 1'b1;
        do_reset(1'b1, 3'h6);
        wait_tx();
        expect_tx(MSG_START_REJECT);
        chk("tx_default", 8'h1, tx_default);
        chk("tx_encrypt", 8'h0, tx_encrypt);
        chk("busy", 8'h0, busy);
        refuse_default = 1'b0;
    endtask : ft_default_reject
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            errors++;
            give_verdict();
        end
    end
    initial
    begin
        reset_n = 1'b0;
        role_fixed = 1'b0;
        start_req = 1'b0;
        stop_req = 1'b0;
        use_default_key = 1'b0;
        refuse_default = 1'b0;
        key_index = 8'h00;
        mode = 3'h0;
        pt_reject_and_timeout();
        pt_start_rekey_stop();
        ft_start_and_timeout();
        ft_default_reject();
        give_verdict();
    end
endmodule : cipher_mode_switch_control_tb

/* peer_mac_model.sv */
// Far link-end model that answers or originates mode-control messages.
`timescale 1ns/1ps
`include "cipher_mode_cfg.svh"
module peer_mac_model
    import cipher_mode_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic frame_tick,
    input wire logic [`FRAME_W-1:0] frame_num,
    input wire logic [2:0] mode,
    input wire logic tx_valid,
    input wire msg_t tx_msg,
    input wire logic tx_default,
    input wire logic [`KEY_W-1:0] tx_key_index,
    output logic rx_valid,
    output msg_t rx_msg,
    output logic rx_default,
    output logic [`KEY_W-1:0] rx_key_index
);
    msg_t pend_r;
    logic [3:0] cnt_r;
    logic done_r;
    logic def_r;
    logic [`KEY_W-1:0] key_r;
    logic conf_seen;
    assign conf_seen = tx_valid && (tx_msg == MSG_START_CONF || tx_msg == MSG_STOP_CONF);
    // Modes: 0 silent, 1 confirm, 2 reject, 3 portable start, 4 one request only,
    // 5 portable stop, 6 one default-key request.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pend_r <= MSG_NONE;
            cnt_r <= 4'h0;
            done_r <= 1'b0;
            def_r <= 1'b0;
            key_r <= '0;
        end
        else if (frame_tick)
        begin
            cnt_r <= 4'h0;
            pend_r <= MSG_NONE;
            def_r <= tx_default || mode == 3'h6;
            key_r <= tx_key_index;
            if (mode == 3'h1 && tx_valid && (tx_msg == MSG_START_REQ || tx_msg == MSG_STOP_REQ))
                pend_r <= msg_t'(tx_msg + 3'h1);
            if (mode == 3'h2 && tx_valid && tx_msg == MSG_START_REQ)
                pend_r <= MSG_START_REJECT;
            if (mode >= 3'h3 && frame_num[0] && !done_r)
            begin
                if (mode == 3'h5)
                    pend_r <= conf_seen ? MSG_STOP_GRANT : MSG_STOP_REQ;
                else
                    pend_r <= conf_seen ? MSG_START_GRANT : MSG_START_REQ;
                done_r <= conf_seen || mode == 3'h4 || mode == 3'h6;
            end
            if (mode == 3'h0)
                done_r <= 1'b0;
        end
        else
            cnt_r <= cnt_r + 4'h1;
    end
    // Idle lines toggle so that a stale value is never mistaken for a message.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_valid <= 1'b0;
            rx_msg <= MSG_NONE;
            rx_default <= 1'b0;
            rx_key_index <= '0;
        end
        else if (cnt_r == 4'h2 && pend_r != MSG_NONE)
        begin
            rx_valid <= 1'b1;
            rx_msg <= pend_r;
            rx_default <= def_r;
            rx_key_index <= key_r;
        end
        else
        begin
            rx_valid <= 1'b0;
            rx_msg <= msg_t'(~rx_msg);
            rx_default <= ~rx_default;
            rx_key_index <= ~rx_key_index;
        end
    end
endmodule : peer_mac_model
